// ---- logic/parallel_io_top.sv ----
// parallel i/o ports with strobed and handshake modes behind axi4-lite
//
// Chosen here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module parallel_io_top
    import pio_pkg::*;
(
    input wire logic I_CLOCK,
    input wire logic I_NRST,
    input wire logic [5:0] I_AXI_AWADDR,
    input wire logic I_AXI_AWVALID,
    output logic O_AXI_AWREADY,
    input wire logic [31:0] I_AXI_WDATA,
    input wire logic [3:0] I_AXI_WSTRB,
    input wire logic I_AXI_WVALID,
    output logic O_AXI_WREADY,
    output logic [1:0] O_AXI_BRESP,
    output logic O_AXI_BVALID,
    input wire logic I_AXI_BREADY,
    input wire logic [5:0] I_AXI_ARADDR,
    input wire logic I_AXI_ARVALID,
    output logic O_AXI_ARREADY,
    output logic [31:0] O_AXI_RDATA,
    output logic [1:0] O_AXI_RRESP,
    output logic O_AXI_RVALID,
    input wire logic I_AXI_RREADY,
    input wire logic [7:0] I_PORT_A,
    output logic [7:0] O_PORT_A,
    output logic [7:0] O_PORT_A_OE,
    output logic [7:0] O_PORT_B,
    input wire logic [7:0] I_PORT_C,
    output logic [7:0] O_PORT_C,
    output logic [7:0] O_PORT_C_OE,
    input wire logic [7:0] I_PORT_D,
    output logic [7:0] O_PORT_D,
    output logic [7:0] O_PORT_D_OE,
    input wire logic [7:0] I_PORT_E,
    input wire logic I_EDGE_LATCH_INPUT,
    output logic O_HANDSHAKE_STROBE_OUT,
    output logic O_EDGE_IRQ
);
    typedef struct packed {
        logic aw_got;
        logic w_got;
        logic [5:0] waddr;
        logic [7:0] wdata;
        logic wlane;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [7:0] rdata;
        logic [31:0] s1;
        logic [31:0] s2;
        logic [31:0] s3;
        logic [31:0] pins;
        logic [7:0] pa_lat;
        logic [7:0] pb_lat;
        logic [7:0] pc_lat;
        logic [7:0] pc_dir;
        logic [7:0] pd_lat;
        logic [7:0] pd_dir;
        logic [7:0] captured;
        logic top_dir;
        logic expanded;
        logic irq_en;
        logic handshake_select;
        logic oin;
        logic pulse_vs_level_select;
        logic edge_polarity_select;
        logic out_strobe_polarity;
        logic flag;
        logic armed;
        logic handshake_strobe_out_act;
        logic [1:0] handshake_strobe_out_cnt;
        logic [7:0] pa_oe;
        logic [7:0] pc_oe;
        logic [7:0] pd_oe;
        logic handshake_strobe_out_pin;
        logic irq;
    } state_t;

    localparam state_t STATE_RESET = '{pc_dir: DIR_RESET, pd_dir: DIR_RESET,
        pa_lat: DATA_RESET, pa_oe: PA_OUT_MASK, handshake_strobe_out_pin: 1'b1, default: '0};

    state_t q;
    state_t d;
    edge_sync_if sync_bus();

    edge_strobe_sync u_sync (
        .i_clk(I_CLOCK),
        .i_nrst(I_NRST),
        .i_pin(I_EDGE_LATCH_INPUT),
        .o_sync(sync_bus)
    );

    // ----------------------------------------------------------------
    // events of this cycle
    // ----------------------------------------------------------------
    logic single;
    logic sel_edge;
    logic wr_fire;
    logic rd_fire;
    logic [5:0] raddr;
    logic wr_pb;
    logic wr_cap;
    logic wr_ctl;
    logic rd_cap;
    logic rd_ctl;
    logic out_hs;
    logic sw_assert;
    logic flag_clr;

    assign single = !q.expanded;
    assign sel_edge = single && (q.edge_polarity_select ? sync_bus.rise : sync_bus.fall);
    assign wr_fire = q.aw_got && q.w_got && !q.bvalid;
    assign rd_fire = I_AXI_ARVALID && q.arready;
    assign raddr = {I_AXI_ARADDR[5:2], 2'b00};
    assign wr_pb = wr_fire && q.wlane && (q.waddr == OFF_PORT_B);
    assign wr_cap = wr_fire && q.wlane && (q.waddr == OFF_CAPTURED);
    assign wr_ctl = wr_fire && q.wlane && (q.waddr == OFF_CTRL);
    assign rd_cap = rd_fire && (raddr == OFF_CAPTURED);
    assign rd_ctl = rd_fire && (raddr == OFF_CTRL);
    assign out_hs = q.handshake_select && q.oin;
    assign sw_assert = q.handshake_select && (q.oin ? wr_cap : rd_cap);
    assign flag_clr = q.armed && (out_hs ? wr_cap : rd_cap);

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [31:0] agree;
        logic [7:0] pa_in;
        logic [7:0] pc_in;
        logic [7:0] pd_in;
        logic [7:0] rd;
        logic hit;
        agree = '0;
        pa_in = '0;
        pc_in = '0;
        pd_in = '0;
        rd = '0;
        hit = 1'b1;
        d = q;
        // pins pass three stages; a bit moves once stages two and three agree
        d.s1 = {I_PORT_A, I_PORT_C, I_PORT_D, I_PORT_E};
        d.s2 = q.s1;
        d.s3 = q.s2;
        agree = ~(q.s2 ^ q.s3);
        d.pins = (agree & q.s3) | (~agree & q.pins);
        pa_in = q.pins[31:24];
        pc_in = q.pins[23:16];
        pd_in = q.pins[15:8];

        // write channel: address and data taken in either order
        if (I_AXI_AWVALID && q.awready) begin
            d.aw_got = 1'b1;
            d.waddr = {I_AXI_AWADDR[5:2], 2'b00};
        end
        if (I_AXI_WVALID && q.wready) begin
            d.w_got = 1'b1;
            d.wdata = I_AXI_WDATA[7:0];
            d.wlane = I_AXI_WSTRB[0];
        end
        if (q.bvalid && I_AXI_BREADY) begin
            d.bvalid = 1'b0;
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
        end
        if (wr_fire) begin
            d.bvalid = 1'b1;
            d.bresp = RESP_OKAY;
            case (q.waddr)
                OFF_PORT_A: begin
                    if (q.wlane) begin
                        d.pa_lat = (q.wdata & ~PA_IN_MASK) | (q.pa_lat & PA_IN_MASK);
                    end
                end
                OFF_PORT_B: d.pb_lat = q.wlane ? q.wdata : q.pb_lat;
                OFF_PORT_C, OFF_CAPTURED: d.pc_lat = q.wlane ? q.wdata : q.pc_lat;
                OFF_DIR_C: d.pc_dir = q.wlane ? q.wdata : q.pc_dir;
                OFF_PORT_D: d.pd_lat = q.wlane ? q.wdata : q.pd_lat;
                OFF_DIR_D: d.pd_dir = q.wlane ? q.wdata : q.pd_dir;
                OFF_PORT_E: d.bresp = RESP_OKAY;
                OFF_CTRL: begin
                    if (q.wlane) begin
                        d.irq_en = q.wdata[CTL_IRQ_EN];
                        d.handshake_select = q.wdata[CTL_HANDSHAKE_SELECT];
                        d.oin = q.wdata[CTL_OIN];
                        d.pulse_vs_level_select = q.wdata[CTL_PLS];
                        d.edge_polarity_select = q.wdata[CTL_EGA];
                        d.out_strobe_polarity = q.wdata[CTL_OUT_STROBE_POLARITY];
                    end
                end
                OFF_PACTL: d.top_dir = q.wlane ? q.wdata[PACTL_TOP_DIR] : q.top_dir;
                OFF_MODE: d.expanded = q.wlane ? q.wdata[MODE_EXPANDED] : q.expanded;
                default: d.bresp = RESP_SLVERR;
            endcase
        end

        // read channel: one read under way at a time
        if (q.rvalid && I_AXI_RREADY) begin
            d.rvalid = 1'b0;
            d.arready = 1'b1;
        end
        if (rd_fire) begin
            case (raddr)
                OFF_PORT_A: begin
                    rd = (pa_in & PA_IN_MASK) | (q.pa_lat & PA_OUT_MASK)
                        | ((q.top_dir ? q.pa_lat : pa_in) & PA_TOP_MASK);
                end
                OFF_PORT_B: rd = q.pb_lat;
                OFF_PORT_C: begin
                    if (out_hs) begin
                        rd = q.pc_lat;
                    end else begin
                        rd = (q.pc_dir & q.pc_lat) | (~q.pc_dir & pc_in);
                    end
                end
                OFF_CAPTURED: rd = q.captured;
                OFF_DIR_C: rd = q.pc_dir;
                OFF_PORT_D: rd = (q.pd_dir & q.pd_lat) | (~q.pd_dir & pd_in);
                OFF_DIR_D: rd = q.pd_dir;
                OFF_PORT_E: rd = q.pins[7:0];
                OFF_CTRL: rd = {q.flag, q.irq_en, 1'b0, q.handshake_select, q.oin, q.pulse_vs_level_select, q.edge_polarity_select, q.out_strobe_polarity};
                OFF_PACTL: rd = {q.top_dir, 7'h00};
                OFF_MODE: rd = {7'h00, q.expanded};
                default: hit = 1'b0;
            endcase
            d.rvalid = 1'b1;
            d.arready = 1'b0;
            d.rdata = rd;
            d.rresp = hit ? RESP_OKAY : RESP_SLVERR;
        end

        // capture and flag; a set in the clearing cycle wins
        if (rd_ctl) begin
            d.armed = q.flag;
        end
        if (flag_clr) begin
            d.flag = 1'b0;
            d.armed = 1'b0;
        end
        if (sel_edge) begin
            d.captured = pc_in;
            d.flag = 1'b1;
        end

        // strobe output: pulse counter, handshake ready
        if (q.handshake_strobe_out_cnt != 2'h0) begin
            d.handshake_strobe_out_cnt = q.handshake_strobe_out_cnt - 2'h1;
            d.handshake_strobe_out_act = (q.handshake_strobe_out_cnt != 2'h1);
        end
        if (!q.handshake_select && wr_pb) begin
            d.handshake_strobe_out_cnt = STROBE_PULSE_CYCLES;
            d.handshake_strobe_out_act = 1'b1;
        end
        if (q.handshake_select && sel_edge) begin
            d.handshake_strobe_out_act = 1'b0;
            d.handshake_strobe_out_cnt = 2'h0;
        end
        if (sw_assert) begin
            d.handshake_strobe_out_act = 1'b1;
            d.handshake_strobe_out_cnt = q.pulse_vs_level_select ? STROBE_PULSE_CYCLES : 2'h0;
        end

        // pin drivers; expanded mode parks the strobe pin high whatever the strobe polarity
        d.handshake_strobe_out_pin = d.expanded ? 1'b1 : (d.out_strobe_polarity ? d.handshake_strobe_out_act : !d.handshake_strobe_out_act);
        d.irq = d.flag && d.irq_en;
        d.pa_oe = PA_OUT_MASK | (d.top_dir ? PA_TOP_MASK : 8'h00);
        if (!d.expanded && d.handshake_select && d.oin && (sync_bus.level != d.edge_polarity_select)) begin
            d.pc_oe = 8'hff;
        end else begin
            d.pc_oe = d.pc_dir;
        end
        d.pd_oe = d.pd_dir;
        d.awready = !d.aw_got;
        d.wready = !d.w_got;
        d.arready = !d.rvalid;
    end

    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            q <= STATE_RESET;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign O_AXI_AWREADY = q.awready;
    assign O_AXI_WREADY = q.wready;
    assign O_AXI_BRESP = q.bresp;
    assign O_AXI_BVALID = q.bvalid;
    assign O_AXI_ARREADY = q.arready;
    assign O_AXI_RDATA = {24'h000000, q.rdata};
    assign O_AXI_RRESP = q.rresp;
    assign O_AXI_RVALID = q.rvalid;
    assign O_PORT_A = q.pa_lat;
    assign O_PORT_A_OE = q.pa_oe;
    assign O_PORT_B = q.pb_lat;
    assign O_PORT_C = q.pc_lat;
    assign O_PORT_C_OE = q.pc_oe;
    assign O_PORT_D = q.pd_lat;
    assign O_PORT_D_OE = q.pd_oe;
    assign O_HANDSHAKE_STROBE_OUT = q.handshake_strobe_out_pin;
    assign O_EDGE_IRQ = q.irq;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge I_CLOCK);
    endclocking
    default disable iff (!I_NRST);

    dir_reset_a: assert property (!$past(I_NRST) |-> (q.pc_dir == 8'h00)
        && (q.pd_dir == 8'h00) && (O_PORT_C_OE == 8'h00))
        else $error("direction bits not clear after reset");
    port_a_dir_a: assert property (O_PORT_A_OE[6:0] == 7'h78
        && O_PORT_A_OE[7] == q.top_dir)
        else $error("port a enables wrong");
    edge_capture_a: assert property (sel_edge |=> (q.captured == $past(q.pins[23:16]))
        && q.flag)
        else $error("edge did not capture port c and set flag");
    irq_request_a: assert property ((sel_edge && q.irq_en && !wr_ctl) |=> O_EDGE_IRQ)
        else $error("interrupt request missing");
    flag_clear_a: assert property ((flag_clr && !sel_edge) |=> !q.flag)
        else $error("flag not cleared by sequence");
    pb_strobe_a: assert property ((wr_pb && !q.handshake_select && !sw_assert)
        |=> q.handshake_strobe_out_act ##1 q.handshake_strobe_out_act)
        else $error("port b strobe shorter than two cycles");
    ready_drop_a: assert property ((q.handshake_select && sel_edge && !sw_assert) |=> !q.handshake_strobe_out_act)
        else $error("ready not dropped on edge");
    ready_assert_a: assert property (sw_assert |=> q.handshake_strobe_out_act)
        else $error("ready not asserted by software access");
    pulse_len_a: assert property ((sw_assert && q.pulse_vs_level_select) ##1 (!sel_edge && !sw_assert) [*2]
        |-> q.handshake_strobe_out_act ##1 !q.handshake_strobe_out_act)
        else $error("pulsed ready not two cycles");
    force_out_a: assert property ((out_hs && single && !wr_fire
        && (sync_bus.level != q.edge_polarity_select)) |=> (O_PORT_C_OE == 8'hff))
        else $error("port c not forced to output");
endmodule : parallel_io_top

// ---- logic/pio_pkg.sv ----
// shared constants for the parallel i/o block
package pio_pkg;
    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [5:0] OFF_PORT_A = 6'h00;
    localparam logic [5:0] OFF_PORT_C = 6'h04;
    localparam logic [5:0] OFF_PORT_B = 6'h08;
    localparam logic [5:0] OFF_CAPTURED = 6'h0c;
    localparam logic [5:0] OFF_DIR_C = 6'h10;
    localparam logic [5:0] OFF_PORT_D = 6'h14;
    localparam logic [5:0] OFF_DIR_D = 6'h18;
    localparam logic [5:0] OFF_PORT_E = 6'h1c;
    localparam logic [5:0] OFF_CTRL = 6'h20;
    localparam logic [5:0] OFF_PACTL = 6'h24;
    localparam logic [5:0] OFF_MODE = 6'h28;
    // ----------------------------------------------------------------
    // parallel_ctrl_reg, port a control and mode register fields
    // ----------------------------------------------------------------
    localparam int CTL_FLAG = 7;
    localparam int CTL_IRQ_EN = 6;
    localparam int CTL_HANDSHAKE_SELECT = 4;
    localparam int CTL_OIN = 3;
    localparam int CTL_PLS = 2;
    localparam int CTL_EGA = 1;
    localparam int CTL_OUT_STROBE_POLARITY = 0;
    localparam int PACTL_TOP_DIR = 7;
    localparam int MODE_EXPANDED = 0;
    // ----------------------------------------------------------------
    // port a layout, reset values, timing
    // ----------------------------------------------------------------
    localparam logic [7:0] PA_IN_MASK = 8'h07;
    localparam logic [7:0] PA_OUT_MASK = 8'h78;
    localparam logic [7:0] PA_TOP_MASK = 8'h80;
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [1:0] STROBE_PULSE_CYCLES = 2'h2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : pio_pkg

// ---- logic/edge_sync_if.sv ----
// synchronised strobe level and edge pulses
`timescale 1ns/1ps
interface edge_sync_if;
    logic level;
    logic rise;
    logic fall;
    modport src (output level, output rise, output fall);
    modport dst (input level, input rise, input fall);
endinterface : edge_sync_if

// ---- logic/edge_strobe_sync.sv ----
// three-stage synchroniser and edge detector for the strobe input
`timescale 1ns/1ps
module edge_strobe_sync
    import pio_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_pin,
    edge_sync_if.src o_sync
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
        logic rise;
        logic fall;
    } sync_state_t;

    sync_state_t q;
    sync_state_t d;

    // ----------------------------------------------------------------
    // sample chain; a change counts once stages two and three agree
    // ----------------------------------------------------------------
    always_comb begin
        d = q;
        d.s1 = i_pin;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.rise = 1'b0;
        d.fall = 1'b0;
        if (q.s2 == q.s3) begin
            d.level = q.s3;
            d.rise = q.s3 && !q.level;
            d.fall = !q.s3 && q.level;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_sync.level = q.level;
    assign o_sync.rise = q.rise;
    assign o_sync.fall = q.fall;

    single_edge_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (q.rise || q.fall) |=> !(q.rise || q.fall))
        else $error("strobe edge reported twice in a row");
endmodule : edge_strobe_sync

// ---- dv/strobe_peer.sv ----
// behavioural peripheral on the strobe link
`timescale 1ns/1ps
module strobe_peer (
    input wire logic i_clk,
    input wire logic i_ready,
    output logic [7:0] o_pc,
    output logic o_strobe
);
    initial begin
        o_pc = 8'h00;
        o_strobe = 1'b1;
    end
    // i_ready is read as active high, so handshake runs use the non-inverted strobe setting
    // each level is held 8 cycles, well beyond the 3-flop synchroniser
    task automatic send(input logic [7:0] d, input logic edge_polarity_select, input logic hs);
        int n;
        n = 0;
        @(posedge i_clk);
        o_strobe <= !edge_polarity_select;
        #1;
        while (hs && i_ready !== 1'b1 && n < 500) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        repeat (4) @(posedge i_clk);
        o_pc <= d;
        repeat (8) @(posedge i_clk);
        o_strobe <= edge_polarity_select;
        repeat (8) @(posedge i_clk);
        o_strobe <= !edge_polarity_select;
        repeat (8) @(posedge i_clk);
        o_pc <= ~d; // released: show the inverse, never a held value
    endtask : send
endmodule : strobe_peer

// ---- dv/tb.sv ----
// self-checking bench for the parallel i/o block
`timescale 1ns/1ps
module tb;
    import pio_pkg::*;
    logic clk, nrst, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
    logic arready, rvalid, edge_latch_input, handshake_strobe_out, irq;
    logic [1:0] bresp, rresp;
    logic [5:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rng, rd;
    logic [7:0] pa_in, pd_pin, pe_in, pa_out, pa_oe, pb_out, pc_drv, pc_pin, pc_out, pc_oe;
    logic [7:0] pd_drv, pd_out, pd_oe, v, q[$];
    int err_count, n_tests, n;
    // pin level: design drives where enabled, the far side elsewhere
    assign pc_pin = (pc_oe & pc_out) | (~pc_oe & pc_drv);
    assign pd_pin = (pd_oe & pd_out) | (~pd_oe & pd_drv);
    parallel_io_top i_parallel_io_top (.I_CLOCK(clk), .I_NRST(nrst), .I_AXI_AWADDR(awaddr),
        .I_AXI_AWVALID(awvalid), .O_AXI_AWREADY(awready), .I_AXI_WDATA(wdata),
        .I_AXI_WSTRB(4'h1), .I_AXI_WVALID(wvalid), .O_AXI_WREADY(wready), .O_AXI_BRESP(bresp),
        .O_AXI_BVALID(bvalid), .I_AXI_BREADY(bready), .I_AXI_ARADDR(araddr),
        .I_AXI_ARVALID(arvalid), .O_AXI_ARREADY(arready), .O_AXI_RDATA(rdata),
        .O_AXI_RRESP(rresp), .O_AXI_RVALID(rvalid), .I_AXI_RREADY(rready), .I_PORT_A(pa_in),
        .O_PORT_A(pa_out), .O_PORT_A_OE(pa_oe), .O_PORT_B(pb_out), .I_PORT_C(pc_pin),
        .O_PORT_C(pc_out), .O_PORT_C_OE(pc_oe), .I_PORT_D(pd_pin), .O_PORT_D(pd_out),
        .O_PORT_D_OE(pd_oe), .I_PORT_E(pe_in), .I_EDGE_LATCH_INPUT(edge_latch_input),
        .O_HANDSHAKE_STROBE_OUT(handshake_strobe_out), .O_EDGE_IRQ(irq));
    strobe_peer i_strobe_peer (.i_clk(clk), .i_ready(handshake_strobe_out), .o_pc(pc_drv), .o_strobe(edge_latch_input));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask : chk
    // offers address and data together; each drops once taken
    task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [1:0] er);
        logic ta, tw;
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end while ((awvalid && !ta) || (wvalid && !tw));
        do @(negedge clk); while (bvalid !== 1'b1);
        chk(bresp, er);
        @(posedge clk);
        bready <= 1'b0;
    endtask : wr
    task automatic rdr(input logic [5:0] a, input logic [1:0] er, output logic [31:0] d);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge clk); while (arready !== 1'b1);
        @(posedge clk);
        arvalid <= 1'b0;
        do @(negedge clk); while (rvalid !== 1'b1);
        d = rdata;
        chk(rresp, er);
        @(posedge clk);
        rready <= 1'b0;
    endtask : rdr
    task automatic rdc(input logic [5:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rdr(a, RESP_OKAY, d);
        chk(d, exp);
    endtask : rdc
    // counts cycles with the strobe output at lvl over a fixed window
    task automatic cnt_act(input logic lvl, output int c);
        c = 0;
        repeat (12) begin
            @(posedge clk);
            #1;
            if (handshake_strobe_out === lvl) c++;
        end
    endtask : cnt_act
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results
    // ----------------------------------------------------------------
    // clock, watchdog, scenarios
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        results();
    end
    initial begin
        {nrst, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata} = 44'h0;
        {pa_in, pe_in, pd_drv} = 24'h0;
        err_count = 0;
        n_tests = 0;
        rng = 32'd36293;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        rdc(OFF_DIR_C, 32'h0);
        rdc(OFF_CTRL, 32'h0);
        chk({pc_oe, pd_oe, handshake_strobe_out}, 17'h1);
        rng = xs(rng);
        pa_in <= rng[7:0];
        pe_in <= rng[15:8];
        wr(OFF_PORT_A, 8'hff, RESP_OKAY);
        rdc(OFF_PORT_A, (pa_in & 8'h87) | 8'h78);
        chk({pa_oe, pa_out}, 16'h78f8);
        wr(OFF_PACTL, 8'h80, RESP_OKAY);
        chk(pa_oe, 8'hf8);
        rdc(OFF_PORT_A, (pa_in & 8'h07) | 8'hf8);
        wr(OFF_PORT_B, rng[23:16], RESP_OKAY);
        rdc(OFF_PORT_B, rng[23:16]);
        chk(pb_out, rng[23:16]);
        wr(OFF_PORT_E, ~pe_in, RESP_OKAY);
        rdc(OFF_PORT_E, pe_in);
        wr(6'h3c, 8'h01, RESP_SLVERR);
        rdr(6'h3c, RESP_SLVERR, rd);
        chk(rd, 32'h0);
        for (int p = 0; p < 2; p++) begin
            rng = xs(rng);
            v = rng[7:0];
            pd_drv <= rng[15:8];
            wr(p ? OFF_PORT_D : OFF_PORT_C, v, RESP_OKAY);
            chk(p ? pd_oe : pc_oe, 8'h0);
            rdc(p ? OFF_PORT_D : OFF_PORT_C, p ? pd_drv : pc_drv);
            wr(p ? OFF_DIR_D : OFF_DIR_C, 8'h0f, RESP_OKAY);
            chk(p ? {pd_oe, pd_out} : {pc_oe, pc_out}, {8'h0f, v});
            rdc(p ? OFF_PORT_D : OFF_PORT_C, (v & 8'h0f) | ((p ? pd_drv : pc_drv) & 8'hf0));
            wr(p ? OFF_DIR_D : OFF_DIR_C, 8'h00, RESP_OKAY);
        end
        for (int e = 0; e < 2; e++) begin
            wr(OFF_CTRL, 8'h40 | (e << 1) | e, RESP_OKAY);
            repeat (2) begin
                rng = xs(rng);
                q.push_back(rng[7:0]);
                i_strobe_peer.send(rng[7:0], e[0], 1'b0);
            end
            rdc(OFF_CTRL, 8'hc0 | (e << 1) | e);
            chk(irq, 1'b1);
            rdc(OFF_CAPTURED, q[$]);
            rdc(OFF_CTRL, 8'h40 | (e << 1) | e);
            chk(irq, 1'b0);
            fork
                wr(OFF_PORT_B, 8'h5a, RESP_OKAY);
                cnt_act(e[0], n);
            join
            chk(n, 2);
        end
        wr(OFF_CTRL, 8'h11, RESP_OKAY);
        chk(handshake_strobe_out, 1'b0);
        rdr(OFF_CAPTURED, RESP_OKAY, rd);
        chk(handshake_strobe_out, 1'b1);
        rng = xs(rng);
        i_strobe_peer.send(rng[7:0], 1'b0, 1'b1);
        chk(handshake_strobe_out, 1'b0);
        rdc(OFF_CTRL, 8'h91);
        wr(OFF_CAPTURED, 8'h3c, RESP_OKAY);
        chk({handshake_strobe_out, pc_out}, 9'h03c);
        wr(OFF_PORT_C, 8'hc3, RESP_OKAY);
        chk({handshake_strobe_out, pc_out}, 9'h0c3);
        rdc(OFF_CAPTURED, rng[7:0]);
        chk(handshake_strobe_out, 1'b1);
        rdc(OFF_CTRL, 8'h11);
        rng = xs(rng);
        i_strobe_peer.send(rng[7:0], 1'b0, 1'b1);
        wr(OFF_CTRL, 8'h15, RESP_OKAY);
        fork
            rdr(OFF_CAPTURED, RESP_OKAY, rd);
            cnt_act(1'b1, n);
        join
        chk(n, 2);
        chk(rd, rng[7:0]);
        wr(OFF_CTRL, 8'h19, RESP_OKAY);
        chk(pc_oe, 8'hff);
        wr(OFF_CAPTURED, 8'ha5, RESP_OKAY);
        chk({handshake_strobe_out, pc_out}, 9'h1a5);
        fork
            i_strobe_peer.send(8'h5a, 1'b0, 1'b0);
            begin
                repeat (18) @(posedge clk);
                #1;
                chk(pc_oe, 8'h00);
                rdc(OFF_PORT_C, 8'ha5);
            end
        join
        chk(handshake_strobe_out, 1'b0);
        rdc(OFF_CTRL, 8'h99);
        wr(OFF_MODE, 8'h01, RESP_OKAY);
        chk(handshake_strobe_out, 1'b1);
        wr(OFF_MODE, 8'h00, RESP_OKAY);
        wr(OFF_CAPTURED, 8'h11, RESP_OKAY);
        rdc(OFF_CTRL, 8'h19);
        chk({handshake_strobe_out, pc_out}, 9'h111);
        results();
    end
endmodule : tb
